// ===== feature_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module feature_register_bank
   import feature_bank_pkg::*;
(
   input wire logic clock, // Port clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic reg_wr_en, // Write strobe from the serial port
   input wire logic reg_rd_en, // Read strobe from the serial port
   input wire logic [ADDR_W-1:0] reg_addr, // Register address
   input wire logic [7:0] reg_wr_data, // Write data
   output logic [7:0] reg_rd_data, // Read data, one cycle after strobe
   input wire logic [1:0] channel_select, // Bit 0 channel A, bit 1 channel B
   input wire logic [7:0] self_test_signature, // Signature from the self-test engine
   input wire logic sync_in, // External sync pulse
   output logic divider_sync, // Sync pulse passed to the clock divider
   input wire logic overrange_a_in, // Raw overrange, channel A
   input wire logic overrange_b_in, // Raw overrange, channel B
   output logic overrange_pin_a, // Gated overrange pin, channel A
   output logic overrange_pin_b, // Gated overrange pin, channel B
   output logic converter_select_a, // 1 = channel A fed by converter B
   output logic converter_select_b, // 1 = channel B fed by converter B
   output logic [15:0] user_pattern_one, // Test pattern word one
   output logic [15:0] user_pattern_two, // Test pattern word two
   output logic output_enable_pin_low_en, // Output enable pin in use
   output logic low_rate_oscillator_detect, // Low encode rate detector on
   output logic low_rate_oscillator_run, // Force the oscillator on
   output logic pulldown_disable, // Drop the data pin pull-down
   output logic [2:0] iq_error_correction_en, // Enables: dc, phase, gain
   output logic [2:0] estimation_run, // Estimators running: dc, phase, gain
   output logic [4:0] gain_loop_time_constant, // Gain loop bandwidth
   output logic [4:0] phase_loop_time_constant, // Phase loop bandwidth
   output logic [4:0] dc_loop_time_constant, // Dc loop bandwidth
   input wire logic [14:0] gain_estimate, // Live gain estimate
   input wire logic [12:0] phase_estimate, // Live phase estimate
   input wire logic [13:0] dc_i_estimate, // Live in-phase dc estimate
   input wire logic [13:0] dc_q_estimate, // Live quadrature dc estimate
   output logic [14:0] gain_correction, // Applied gain correction
   output logic [12:0] phase_correction, // Applied phase correction
   output logic [13:0] dc_i_correction, // Applied in-phase dc correction
   output logic [13:0] dc_q_correction, // Applied quadrature dc correction
   output logic requantizer_enable, // Noise shaping requantizer on
   output requant_mode_t requantizer_mode // Requantizer filter mode
);
   logic [7:0] pattern_one_low_reg;
   logic [7:0] pattern_one_high_reg;
   logic [7:0] pattern_two_low_reg;
   logic [7:0] pattern_two_high_reg;
   logic [7:0] signature_reg;
   logic [7:0] feature_reg [2];
   logic [7:0] assign_reg [2];
   logic [7:0] sync_ctrl_reg;
   logic [7:0] user_cfg_reg;
   logic [7:0] iq_ctrl_a_reg;
   logic [7:0] iq_ctrl_b_reg;
   logic [7:0] gain_bw_reg;
   logic [7:0] phase_bw_reg;
   logic [7:0] dc_bw_reg;
   logic [7:0] init_gain_low_reg;
   logic [7:0] init_gain_high_reg;
   logic [7:0] init_phase_low_reg;
   logic [7:0] init_phase_high_reg;
   logic [7:0] init_dc_i_low_reg;
   logic [7:0] init_dc_i_high_reg;
   logic [7:0] init_dc_q_low_reg;
   logic [7:0] init_dc_q_high_reg;
   logic [7:0] requant_reg;
   logic [7:0] rd_next;
   logic sync_self_clear;
   logic sync_write;
   logic [CORR_W-1:0] init_value [NUM_CORR];
   logic [CORR_W-1:0] live_value [NUM_CORR];
   logic [CORR_W-1:0] applied_reg [NUM_CORR];

   assign sync_write = reg_wr_en && (reg_addr == OFS_DIVIDER_SYNC);

   // Global registers; masks keep unused bits at zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pattern_one_low_reg <= RST_ZERO;
         pattern_one_high_reg <= RST_ZERO;
         pattern_two_low_reg <= RST_ZERO;
         pattern_two_high_reg <= RST_ZERO;
         user_cfg_reg <= RST_USER_CONFIG_SECOND;
         iq_ctrl_a_reg <= RST_ZERO;
         iq_ctrl_b_reg <= RST_ZERO;
         gain_bw_reg <= RST_LOOP_BW;
         phase_bw_reg <= RST_LOOP_BW;
         dc_bw_reg <= RST_LOOP_BW;
         requant_reg <= RST_ZERO;
      end else if (reg_wr_en) begin
         unique case (reg_addr)
            OFS_PATTERN_ONE_LOW: pattern_one_low_reg <= reg_wr_data;
            OFS_PATTERN_ONE_HIGH: pattern_one_high_reg <= reg_wr_data;
            OFS_PATTERN_TWO_LOW: pattern_two_low_reg <= reg_wr_data;
            OFS_PATTERN_TWO_HIGH: pattern_two_high_reg <= reg_wr_data;
            OFS_USER_CONFIG_SECOND: user_cfg_reg <= reg_wr_data & MASK_USER_CONFIG_SECOND;
            OFS_IQ_CONTROL_A: iq_ctrl_a_reg <= reg_wr_data & MASK_IQ_CONTROL_A;
            OFS_IQ_CONTROL_B: iq_ctrl_b_reg <= reg_wr_data & MASK_IQ_CONTROL_B;
            OFS_GAIN_LOOP_BW: gain_bw_reg <= reg_wr_data & MASK_LOOP_BW;
            OFS_PHASE_LOOP_BW: phase_bw_reg <= reg_wr_data & MASK_LOOP_BW;
            OFS_DC_LOOP_BW: dc_bw_reg <= reg_wr_data & MASK_LOOP_BW;
            OFS_REQUANT_CONTROL: requant_reg <= reg_wr_data & MASK_LOOP_BW & 8'h07;
            default: ;
         endcase
      end
   end

   // Initial correction values
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         init_gain_low_reg <= RST_ZERO;
         init_gain_high_reg <= RST_ZERO;
         init_phase_low_reg <= RST_ZERO;
         init_phase_high_reg <= RST_ZERO;
         init_dc_i_low_reg <= RST_ZERO;
         init_dc_i_high_reg <= RST_ZERO;
         init_dc_q_low_reg <= RST_ZERO;
         init_dc_q_high_reg <= RST_ZERO;
      end else if (reg_wr_en) begin
         unique case (reg_addr)
            OFS_INIT_GAIN_LOW: init_gain_low_reg <= reg_wr_data;
            OFS_INIT_GAIN_HIGH: init_gain_high_reg <= reg_wr_data & MASK_GAIN_HIGH;
            OFS_INIT_PHASE_LOW: init_phase_low_reg <= reg_wr_data;
            OFS_INIT_PHASE_HIGH: init_phase_high_reg <= reg_wr_data & MASK_PHASE_HIGH;
            OFS_INIT_DC_I_LOW: init_dc_i_low_reg <= reg_wr_data;
            OFS_INIT_DC_I_HIGH: init_dc_i_high_reg <= reg_wr_data & MASK_DC_HIGH;
            OFS_INIT_DC_Q_LOW: init_dc_q_low_reg <= reg_wr_data;
            OFS_INIT_DC_Q_HIGH: init_dc_q_high_reg <= reg_wr_data & MASK_DC_HIGH;
            default: ;
         endcase
      end
   end

   // A software write in the same cycle as the self-clear wins
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_ctrl_reg <= RST_DIVIDER_SYNC;
      end else if (sync_write) begin
         sync_ctrl_reg <= reg_wr_data & MASK_DIVIDER_SYNC;
      end else if (sync_self_clear) begin
         sync_ctrl_reg[POS_DIVIDER_SYNC_EN] <= 1'b0;
      end
   end

   // Channel-local registers follow the channel select bits
   for (genvar c = 0; c < 2; c++) begin : g_local
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            feature_reg[c] <= RST_FEATURE_CONTROL;
            assign_reg[c] <= (c == 0) ? RST_ASSIGN_CH_A : RST_ASSIGN_CH_B;
         end else if (reg_wr_en && channel_select[c]) begin
            if (reg_addr == OFS_FEATURE_CONTROL) begin
               feature_reg[c] <= reg_wr_data & MASK_BIT0;
            end
            if (reg_addr == OFS_OUTPUT_ASSIGN) begin
               assign_reg[c] <= reg_wr_data & MASK_BIT0;
            end
         end
      end
   end

   // Signature is sampled every cycle so reads see the engine's latest byte
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         signature_reg <= RST_ZERO;
      end else begin
         signature_reg <= self_test_signature;
      end
   end

   always_comb begin
      rd_next = 8'h00;
      unique case (reg_addr)
         OFS_PATTERN_ONE_LOW: rd_next = pattern_one_low_reg;
         OFS_PATTERN_ONE_HIGH: rd_next = pattern_one_high_reg;
         OFS_PATTERN_TWO_LOW: rd_next = pattern_two_low_reg;
         OFS_PATTERN_TWO_HIGH: rd_next = pattern_two_high_reg;
         OFS_SELF_TEST_SIG_LOW: rd_next = signature_reg;
         OFS_FEATURE_CONTROL: rd_next = channel_select[0] ? feature_reg[0] : feature_reg[1];
         OFS_OUTPUT_ASSIGN: rd_next = channel_select[0] ? assign_reg[0] : assign_reg[1];
         OFS_DIVIDER_SYNC: rd_next = sync_ctrl_reg;
         OFS_USER_CONFIG_SECOND: rd_next = user_cfg_reg;
         OFS_IQ_CONTROL_A: rd_next = iq_ctrl_a_reg;
         OFS_IQ_CONTROL_B: rd_next = iq_ctrl_b_reg;
         OFS_GAIN_LOOP_BW: rd_next = gain_bw_reg;
         OFS_PHASE_LOOP_BW: rd_next = phase_bw_reg;
         OFS_DC_LOOP_BW: rd_next = dc_bw_reg;
         OFS_INIT_GAIN_LOW: rd_next = init_gain_low_reg;
         OFS_INIT_GAIN_HIGH: rd_next = init_gain_high_reg;
         OFS_INIT_PHASE_LOW: rd_next = init_phase_low_reg;
         OFS_INIT_PHASE_HIGH: rd_next = init_phase_high_reg;
         OFS_INIT_DC_I_LOW: rd_next = init_dc_i_low_reg;
         OFS_INIT_DC_I_HIGH: rd_next = init_dc_i_high_reg;
         OFS_INIT_DC_Q_LOW: rd_next = init_dc_q_low_reg;
         OFS_INIT_DC_Q_HIGH: rd_next = init_dc_q_high_reg;
         OFS_REQUANT_CONTROL: rd_next = requant_reg;
         default: rd_next = 8'h00;
      endcase
   end

   // Read data holds until the next read strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rd_data <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rd_data <= rd_next;
      end
   end

   divider_sync_gate u_sync_gate (
      .clock(clock),
      .sys_rst(sys_rst),
      .sync_in(sync_in),
      .master_enable(sync_ctrl_reg[POS_MASTER_SYNC]),
      .divider_enable(sync_ctrl_reg[POS_DIVIDER_SYNC_EN]),
      .next_only(sync_ctrl_reg[POS_NEXT_SYNC_ONLY]),
      .divider_sync(divider_sync),
      .self_clear(sync_self_clear)
   );

   // Gated pins are registered to keep the output free of glitches
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         overrange_pin_a <= 1'b0;
         overrange_pin_b <= 1'b0;
      end else begin
         overrange_pin_a <= overrange_a_in && feature_reg[0][0];
         overrange_pin_b <= overrange_b_in && feature_reg[1][0];
      end
   end

   assign converter_select_a = assign_reg[0][0];
   assign converter_select_b = assign_reg[1][0];
   assign user_pattern_one = {pattern_one_high_reg, pattern_one_low_reg};
   assign user_pattern_two = {pattern_two_high_reg, pattern_two_low_reg};
   assign output_enable_pin_low_en = user_cfg_reg[POS_OUTPUT_ENABLE_PIN];
   assign low_rate_oscillator_detect = user_cfg_reg[POS_OSC_DETECT];
   assign low_rate_oscillator_run = user_cfg_reg[POS_OSC_RUN];
   assign pulldown_disable = user_cfg_reg[POS_PULLDOWN_OFF];
   assign iq_error_correction_en = iq_ctrl_a_reg[2:0];
   assign gain_loop_time_constant = gain_bw_reg[4:0];
   assign phase_loop_time_constant = phase_bw_reg[4:0];
   assign dc_loop_time_constant = dc_bw_reg[4:0];
   assign requantizer_enable = requant_reg[POS_REQUANT_ENABLE];
   // Mode 11 folds into band pass
   assign requantizer_mode = requant_reg[POS_REQUANT_MODE + 1] ? MODE_BAND_PASS
      : (requant_reg[POS_REQUANT_MODE] ? MODE_HIGH_PASS : MODE_LOW_PASS);

   // Estimation halts on freeze; bit order dc, phase, gain
   assign estimation_run = iq_ctrl_a_reg[2:0] & ~iq_ctrl_a_reg[POS_FREEZE_BASE +: 3];

   assign init_value[0] = {init_gain_high_reg[6:0], init_gain_low_reg};
   assign init_value[1] = {2'b00, init_phase_high_reg[4:0], init_phase_low_reg};
   assign init_value[2] = {1'b0, init_dc_i_high_reg[5:0], init_dc_i_low_reg};
   assign init_value[3] = {1'b0, init_dc_q_high_reg[5:0], init_dc_q_low_reg};
   assign live_value[0] = gain_estimate;
   assign live_value[1] = {2'b00, phase_estimate};
   assign live_value[2] = {1'b0, dc_i_estimate};
   assign live_value[3] = {1'b0, dc_q_estimate};

   // Both dc entries share the dc control bits
   for (genvar i = 0; i < NUM_CORR; i++) begin : g_corr
      localparam int K = (i == 3) ? 2 : i;
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            applied_reg[i] <= '0;
         end else if (!iq_ctrl_a_reg[K]) begin
            applied_reg[i] <= '0;
         end else if (iq_ctrl_b_reg[K]) begin
            applied_reg[i] <= init_value[i];
         end else if (!iq_ctrl_a_reg[POS_FREEZE_BASE + K]) begin
            applied_reg[i] <= live_value[i];
         end
      end
   end

   assign gain_correction = applied_reg[0];
   assign phase_correction = applied_reg[1][12:0];
   assign dc_i_correction = applied_reg[2][13:0];
   assign dc_q_correction = applied_reg[3][13:0];
endmodule : feature_register_bank
`default_nettype wire

// ===== feature_bank_pkg.sv
package feature_bank_pkg;
   localparam int ADDR_W = 13;

   localparam logic [12:0] OFS_PATTERN_ONE_LOW = 13'h019;
   localparam logic [12:0] OFS_PATTERN_ONE_HIGH = 13'h01a;
   localparam logic [12:0] OFS_PATTERN_TWO_LOW = 13'h01b;
   localparam logic [12:0] OFS_PATTERN_TWO_HIGH = 13'h01c;
   localparam logic [12:0] OFS_SELF_TEST_SIG_LOW = 13'h024;
   localparam logic [12:0] OFS_FEATURE_CONTROL = 13'h02a;
   localparam logic [12:0] OFS_OUTPUT_ASSIGN = 13'h02e;
   localparam logic [12:0] OFS_DIVIDER_SYNC = 13'h100;
   localparam logic [12:0] OFS_USER_CONFIG_SECOND = 13'h101;
   localparam logic [12:0] OFS_IQ_CONTROL_A = 13'h110;
   localparam logic [12:0] OFS_IQ_CONTROL_B = 13'h111;
   localparam logic [12:0] OFS_GAIN_LOOP_BW = 13'h112;
   localparam logic [12:0] OFS_PHASE_LOOP_BW = 13'h113;
   localparam logic [12:0] OFS_DC_LOOP_BW = 13'h114;
   localparam logic [12:0] OFS_INIT_GAIN_LOW = 13'h116;
   localparam logic [12:0] OFS_INIT_GAIN_HIGH = 13'h117;
   localparam logic [12:0] OFS_INIT_PHASE_LOW = 13'h118;
   localparam logic [12:0] OFS_INIT_PHASE_HIGH = 13'h119;
   localparam logic [12:0] OFS_INIT_DC_I_LOW = 13'h11a;
   localparam logic [12:0] OFS_INIT_DC_I_HIGH = 13'h11b;
   localparam logic [12:0] OFS_INIT_DC_Q_LOW = 13'h11c;
   localparam logic [12:0] OFS_INIT_DC_Q_HIGH = 13'h11d;
   localparam logic [12:0] OFS_REQUANT_CONTROL = 13'h11e;

   // Writable bit masks; everything outside them stays zero
   localparam logic [7:0] MASK_BIT0 = 8'h01;
   localparam logic [7:0] MASK_DIVIDER_SYNC = 8'h07;
   localparam logic [7:0] MASK_USER_CONFIG_SECOND = 8'h8d;
   localparam logic [7:0] MASK_IQ_CONTROL_A = 8'h3f;
   localparam logic [7:0] MASK_IQ_CONTROL_B = 8'h07;
   localparam logic [7:0] MASK_LOOP_BW = 8'h1f;
   localparam logic [7:0] MASK_GAIN_HIGH = 8'h7f;
   localparam logic [7:0] MASK_PHASE_HIGH = 8'h1f;
   localparam logic [7:0] MASK_DC_HIGH = 8'h3f;

   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_FEATURE_CONTROL = 8'h01;
   localparam logic [7:0] RST_ASSIGN_CH_A = 8'h00;
   localparam logic [7:0] RST_ASSIGN_CH_B = 8'h01;
   localparam logic [7:0] RST_DIVIDER_SYNC = 8'h01;
   localparam logic [7:0] RST_USER_CONFIG_SECOND = 8'h88;
   localparam logic [7:0] RST_LOOP_BW = 8'h02;

   // Field positions
   localparam int POS_MASTER_SYNC = 0;
   localparam int POS_DIVIDER_SYNC_EN = 1;
   localparam int POS_NEXT_SYNC_ONLY = 2;
   localparam int POS_PULLDOWN_OFF = 0;
   localparam int POS_OSC_RUN = 2;
   localparam int POS_OSC_DETECT = 3;
   localparam int POS_OUTPUT_ENABLE_PIN = 7;
   localparam int POS_FREEZE_BASE = 3;
   localparam int POS_REQUANT_ENABLE = 0;
   localparam int POS_REQUANT_MODE = 1;

   // Correction entries: gain, phase, in-phase dc, quadrature dc
   localparam int NUM_CORR = 4;
   localparam int CORR_W = 15;

   typedef enum logic [1:0] {
      MODE_LOW_PASS = 2'b00,
      MODE_HIGH_PASS = 2'b01,
      MODE_BAND_PASS = 2'b10
   } requant_mode_t;
endpackage : feature_bank_pkg

// ===== divider_sync_gate.sv
`timescale 1ns/1ps
`default_nettype none
module divider_sync_gate (
   input wire logic clock, // Port clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic sync_in, // Incoming sync pulse
   input wire logic master_enable, // Master sync enable bit
   input wire logic divider_enable, // Divider sync enable bit
   input wire logic next_only, // Sync once, then drop divider enable
   output logic divider_sync, // Registered sync pulse to the divider
   output logic self_clear // Request to clear divider enable
);
   logic pass;

   assign pass = sync_in && master_enable && divider_enable;
   assign self_clear = pass && next_only;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         divider_sync <= 1'b0;
      end else begin
         divider_sync <= pass;
      end
   end
endmodule : divider_sync_gate
`default_nettype wire

// ===== feature_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module feature_bank_monitor
   import feature_bank_pkg::*;
(
   input wire logic clock, // Port clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic reg_wr_en, // Write strobe
   input wire logic reg_rd_en, // Read strobe
   input wire logic [ADDR_W-1:0] reg_addr, // Address
   input wire logic [7:0] reg_wr_data, // Write data
   input wire logic [7:0] reg_rd_data, // Read data
   input wire logic [7:0] self_test_signature, // Signature in
   input wire logic sync_in, // Sync in
   input wire logic divider_sync, // Sync out
   input wire logic overrange_a_in, // Raw overrange A
   input wire logic overrange_pin_a, // Gated pin A
   input wire logic [15:0] user_pattern_one, // Pattern one
   input wire logic [15:0] user_pattern_two, // Pattern two
   input wire logic [2:0] iq_error_correction_en, // Enables
   input wire logic [2:0] estimation_run, // Estimators
   input wire logic [4:0] dc_loop_time_constant, // Dc loop
   input wire logic [14:0] gain_correction, // Gain out
   input wire logic requantizer_enable, // Requantizer on
   input wire requant_mode_t requantizer_mode // Mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence wr_to(logic [12:0] a);
      reg_wr_en && reg_addr == a;
   endsequence
   sequence sig_read;
      reg_rd_en && reg_addr == OFS_SELF_TEST_SIG_LOW;
   endsequence
   a_pattern_high: assert property (
      wr_to(OFS_PATTERN_ONE_HIGH) |=> user_pattern_one[15:8] == $past(reg_wr_data))
      else $error("pattern one high byte wrong");
   a_pattern_low: assert property (
      wr_to(OFS_PATTERN_TWO_LOW) |=> user_pattern_two[7:0] == $past(reg_wr_data))
      else $error("pattern two low byte wrong");
   // Register samples the input, read data adds a second stage
   a_signature_read: assert property (
      sig_read |=> reg_rd_data == $past(self_test_signature, 2))
      else $error("signature readback wrong");
   a_overrange_gate: assert property (
      overrange_pin_a |-> $past(overrange_a_in)) else $error("overrange pin without cause");
   a_sync_cause: assert property (
      divider_sync |-> $past(sync_in)) else $error("divider sync without input pulse");
   a_estimate_gate: assert property (
      (estimation_run & ~iq_error_correction_en) == 3'h0) else $error("estimator runs disabled");
   a_gain_off_zero: assert property (
      !iq_error_correction_en[0] |=> gain_correction == 15'h0000)
      else $error("gain correction while disabled");
   a_requant_write: assert property (
      wr_to(OFS_REQUANT_CONTROL) |=> requantizer_enable == $past(reg_wr_data[0])
      && requantizer_mode[1] == $past(reg_wr_data[2])
      && requantizer_mode[0] == ($past(reg_wr_data[1]) && !$past(reg_wr_data[2])))
      else $error("requantizer control wrong");
   a_dc_bw_write: assert property (
      wr_to(OFS_DC_LOOP_BW) |=> dc_loop_time_constant == $past(reg_wr_data[4:0]))
      else $error("dc loop constant wrong");
endmodule : feature_bank_monitor
bind feature_register_bank feature_bank_monitor u_feature_bank_monitor (.clock, .sys_rst,
   .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .self_test_signature,
   .sync_in, .divider_sync, .overrange_a_in, .overrange_pin_a, .user_pattern_one,
   .user_pattern_two, .iq_error_correction_en, .estimation_run, .dc_loop_time_constant,
   .gain_correction, .requantizer_enable, .requantizer_mode);
`default_nettype wire

// ===== feature_register_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module feature_register_bank_tb
   import feature_bank_pkg::*;
;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [12:0] reg_addr = 13'h000;
   logic [7:0] reg_wr_data = 8'h00;
   logic [1:0] channel_select = 2'h1;
   logic [7:0] self_test_signature = 8'h00;
   logic sync_in = 1'b0;
   logic overrange_a_in = 1'b1;
   logic overrange_b_in = 1'b1;
   logic [14:0] gain_estimate = 15'h0000;
   logic [12:0] phase_estimate = 13'h0000;
   logic [13:0] dc_i_estimate = 14'h0000;
   logic [13:0] dc_q_estimate = 14'h0000;
   logic [7:0] reg_rd_data;
   logic divider_sync, overrange_pin_a, overrange_pin_b, converter_select_a, converter_select_b;
   logic [15:0] user_pattern_one, user_pattern_two;
   logic output_enable_pin_low_en, low_rate_oscillator_detect, requantizer_enable;
   logic low_rate_oscillator_run, pulldown_disable;
   logic [2:0] estimation_run, iq_error_correction_en;
   logic [4:0] gain_loop_time_constant, phase_loop_time_constant, dc_loop_time_constant;
   logic [14:0] gain_correction;
   logic [12:0] phase_correction;
   logic [13:0] dc_i_correction, dc_q_correction;
   requant_mode_t requantizer_mode;
   int n_errors = 0;
   int checks = 0;
   int n_sync = 0;
   // Unmapped 0x1d, 0x115 and 0x11f ride along to prove they stay empty
   logic [12:0] regs [$] = '{13'h019, 13'h01a, 13'h01b, 13'h01c, 13'h01d, 13'h024, 13'h100,
      13'h101, 13'h110, 13'h111, 13'h112, 13'h113, 13'h114, 13'h115, 13'h116, 13'h117,
      13'h118, 13'h119, 13'h11a, 13'h11b, 13'h11c, 13'h11d, 13'h11e, 13'h11f};

   feature_register_bank u_feature_register_bank (
      .clock, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
      .channel_select, .self_test_signature, .sync_in, .divider_sync, .overrange_a_in,
      .overrange_b_in, .overrange_pin_a, .overrange_pin_b, .converter_select_a,
      .converter_select_b, .user_pattern_one, .user_pattern_two, .output_enable_pin_low_en,
      .low_rate_oscillator_detect, .low_rate_oscillator_run, .pulldown_disable,
      .iq_error_correction_en, .estimation_run, .gain_loop_time_constant,
      .phase_loop_time_constant, .dc_loop_time_constant, .gain_estimate, .phase_estimate,
      .dc_i_estimate, .dc_q_estimate, .gain_correction, .phase_correction, .dc_i_correction,
      .dc_q_correction, .requantizer_enable, .requantizer_mode);

   always #2.5 clock = ~clock;
   always @(posedge clock) if (divider_sync === 1'b1) n_sync <= n_sync + 1;

   function automatic logic [7:0] rst_of(logic [12:0] a);
      case (a)
         13'h100: return 8'h01;
         13'h101: return 8'h88;
         13'h112, 13'h113, 13'h114: return 8'h02;
         default: return 8'h00;
      endcase
   endfunction : rst_of

   function automatic logic [7:0] mask_of(logic [12:0] a);
      case (a)
         13'h019, 13'h01a, 13'h01b, 13'h01c, 13'h116, 13'h118, 13'h11a, 13'h11c: return 8'hff;
         13'h100, 13'h111, 13'h11e: return 8'h07;
         13'h101: return 8'h8d;
         13'h110, 13'h11b, 13'h11d: return 8'h3f;
         13'h112, 13'h113, 13'h114, 13'h119: return 8'h1f;
         13'h117: return 8'h7f;
         default: return 8'h00;
      endcase
   endfunction : mask_of

   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tick(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic wr(logic [12:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      tick(1);
      reg_wr_en = 1'b0;
      tick(1);
   endtask : wr

   task automatic rd(logic [12:0] a, logic [7:0] e);
      reg_addr = a;
      reg_rd_en = 1'b1;
      tick(1);
      reg_rd_en = 1'b0;
      chk($sformatf("reg %h", a), {8'h00, reg_rd_data}, {8'h00, e});
      tick(1);
   endtask : rd

   task automatic reset_dut();
      sys_rst = 1'b1;
      tick(20);
      sys_rst = 1'b0;
   endtask : reset_dut

   task automatic pulse(int n, int e);
      n_sync = 0;
      sync_in = 1'b1;
      tick(n);
      sync_in = 1'b0;
      tick(3);
      chk("sync count", 16'(n_sync), 16'(e));
   endtask : pulse

   task automatic t_reset();
      foreach (regs[i]) rd(regs[i], rst_of(regs[i]));
      rd(13'h02a, 8'h01);
      rd(13'h02e, 8'h00);
      channel_select = 2'h2;
      rd(13'h02a, 8'h01);
      rd(13'h02e, 8'h01);
      chk("assign", {14'h0, converter_select_b, converter_select_a}, 16'h2);
      chk("overrange", {14'h0, overrange_pin_b, overrange_pin_a}, 16'h3);
      chk("user_config_second", {14'h0, output_enable_pin_low_en, low_rate_oscillator_detect}, 16'h3);
      chk("user_config_second low", {14'h0, low_rate_oscillator_run, pulldown_disable}, 16'h0);
      chk("loop bw", {1'b0, gain_loop_time_constant, phase_loop_time_constant,
         dc_loop_time_constant}, 16'h0842);
      $display("Done reset values");
   endtask : t_reset

   task automatic t_masks();
      self_test_signature = 8'h5a;
      tick(2);
      foreach (regs[i]) begin
         wr(regs[i], 8'hff);
         rd(regs[i], (regs[i] == 13'h024) ? 8'h5a : mask_of(regs[i]));
      end
      chk("user_config_second low", {14'h0, low_rate_oscillator_run, pulldown_disable}, 16'h3);
      chk("loop bw", {1'b0, gain_loop_time_constant, phase_loop_time_constant,
         dc_loop_time_constant}, 16'h7fff);
      wr(13'h019, 8'h34);
      wr(13'h01a, 8'h12);
      wr(13'h01b, 8'hcd);
      wr(13'h01c, 8'hab);
      chk("pattern one", user_pattern_one, 16'h1234);
      chk("pattern two", user_pattern_two, 16'habcd);
      for (int m = 0; m < 4; m++) begin
         wr(13'h11e, 8'(m * 2 + 1));
         chk("requant mode", 16'(requantizer_mode), 16'((m == 3) ? 2 : m));
         chk("requant on", 16'(requantizer_enable), 16'h1);
      end
      $display("Done access masks");
   endtask : t_masks

   task automatic t_local();
      channel_select = 2'h1;
      wr(13'h02a, 8'h00);
      tick(1);
      chk("pins", {14'h0, overrange_pin_b, overrange_pin_a}, 16'h2);
      channel_select = 2'h0;
      wr(13'h02e, 8'h01);
      chk("assign none", {14'h0, converter_select_b, converter_select_a}, 16'h2);
      channel_select = 2'h2;
      wr(13'h02e, 8'h00);
      chk("assign b", {14'h0, converter_select_b, converter_select_a}, 16'h0);
      channel_select = 2'h3;
      wr(13'h02e, 8'h01);
      chk("assign both", {14'h0, converter_select_b, converter_select_a}, 16'h3);
      $display("Done channel registers");
   endtask : t_local

   task automatic t_sync();
      wr(13'h100, 8'h03);
      pulse(2, 2);
      wr(13'h100, 8'h01);
      pulse(2, 0);
      wr(13'h100, 8'h07);
      pulse(3, 1);
      rd(13'h100, 8'h05);
      pulse(1, 0);
      $display("Done divider sync");
   endtask : t_sync

   task automatic t_corr();
      gain_estimate = 15'h1234;
      dc_q_estimate = 14'h2468;
      wr(13'h110, 8'h07);
      tick(1);
      chk("enables", 16'(iq_error_correction_en), 16'h7);
      chk("gain follow", 16'(gain_correction), 16'h1234);
      chk("dc q follow", 16'(dc_q_correction), 16'h2468);
      wr(13'h110, 8'h3f);
      chk("estimators", 16'(estimation_run), 16'h0);
      gain_estimate = 15'h0001;
      dc_q_estimate = 14'h0001;
      tick(2);
      chk("gain frozen", 16'(gain_correction), 16'h1234);
      chk("dc q frozen", 16'(dc_q_correction), 16'h2468);
      foreach (regs[i]) if (regs[i] > 13'h115 && regs[i] < 13'h11e) wr(regs[i], 8'(i * 17));
      wr(13'h111, 8'h07);
      tick(1);
      chk("gain forced", 16'(gain_correction), 16'h7fee);
      chk("phase forced", 16'(phase_correction), 16'h0110);
      chk("dc i forced", 16'(dc_i_correction), 16'h0332);
      chk("dc q forced", 16'(dc_q_correction), 16'h2554);
      $display("Done correction");
   endtask : t_corr

   task automatic stop_test();
      $display("Checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   initial begin
      reset_dut();
      t_reset();
      t_masks();
      reset_dut();
      t_local();
      t_sync();
      t_corr();
      stop_test();
   end

   // Whole run is well under 2000 cycles
   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      stop_test();
   end
endmodule : feature_register_bank_tb
`default_nettype wire
